// [pps_pkg.sv]
package pps_pkg;
	localparam logic [15:0] PPS_PROM_PROGRAM_CONTROL_ADDR    = 16'h103b;
	localparam logic [15:0] PPS_OPTS_ADDR     = 16'h103f;
	localparam logic [15:0] PPS_ARRAY_BASE    = 16'hd000;
	localparam logic [15:0] PPS_ARRAY_LAST    = 16'hffff;
	localparam int          PPS_ARRAY_BYTES   = 12288;
	localparam int          PPS_ADDR_W        = 14;
	localparam int          PPS_LATCH_BIT     = 5;
	localparam int          PPS_VOLT_BIT      = 0;
	localparam int          PPS_ARRAY_EN_BIT  = 1;
	localparam logic [7:0]  PPS_PROM_PROGRAM_CONTROL_RESET   = 8'h00;
	localparam logic [7:0]  PPS_OPTS_RESET    = 8'h08;
	localparam logic [7:0]  PPS_ERASED        = 8'hff;
	localparam logic [7:0]  PPS_OPTS_WMASK    = 8'h07;
	localparam int          PPS_PROG_CYCLES   = 1;
endpackage : pps_pkg

// [pps_array.sv]
module pps_array
	import pps_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  clk_en,
	input  wire logic                  prog_en,
	input  wire logic [PPS_ADDR_W-1:0] prog_addr,
	input  wire logic [7:0]            prog_data,
	input  wire logic                  rd_en,
	input  wire logic [PPS_ADDR_W-1:0] rd_addr,
	output logic      [7:0]            rd_data
);
	logic [7:0] mem [0:PPS_ARRAY_BYTES-1];

	initial begin
		for (int i = 0; i < PPS_ARRAY_BYTES; i++) begin
			mem[i] = PPS_ERASED;
		end
	end

	always_ff @(posedge clock) begin
		// One-time programmable cell: only ones can be cleared
		if (clk_en && prog_en) begin
			mem[prog_addr] <= mem[prog_addr] & prog_data;
		end
		if (clk_en && rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : pps_array

// [pps_sequencer.sv]
// The plain strobed port was decided locally.
module pps_sequencer
	import pps_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        special_mode,
	input  wire logic        vpp_present_pin,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [7:0]  bus_rdata,
	output logic             prog_power_on,
	output logic             array_busy
);
	typedef enum logic [0:0] {
		PPS_IDLE  = 1'b0,
		PPS_BURN  = 1'b1
	} pps_state_e;

	function automatic logic pps_in_array(input logic [15:0] a);
		pps_in_array = (a >= PPS_ARRAY_BASE);
	endfunction : pps_in_array

	function automatic logic [PPS_ADDR_W-1:0] pps_offset(input logic [15:0] a);
		logic [15:0] d;
		d = a - PPS_ARRAY_BASE;
		pps_offset = d[PPS_ADDR_W-1:0];
	endfunction : pps_offset

	logic                  vpp_s1;
	logic                  vpp_s2;
	logic                  mode_s1;
	logic                  mode_s2;
	logic                  prom_latch_enable;
	logic                  prom_program_voltage_on;
	logic [7:0]            nonvolatile_options;
	logic [PPS_ADDR_W-1:0] latched_addr;
	logic [7:0]            latched_data;
	logic                  latched_valid;
	logic                  rd_pending;
	logic                  rd_array;
	logic [7:0]            rd_reg;
	pps_state_e            state;
	logic                  next_latch;
	logic                  next_volt;
	logic [7:0]            next_opts;
	logic [PPS_ADDR_W-1:0] next_laddr;
	logic [7:0]            next_ldata;
	logic                  next_lvalid;
	logic                  next_rd_pending;
	logic                  next_rd_array;
	logic [7:0]            next_rd_reg;
	pps_state_e            next_state;
	logic                  prom_program_allow;
	logic                  burn;
	logic [7:0]            arr_rdata;
	logic                  arr_rd_en;

	// Pins are asynchronous to the bus clock
	// Only the second stage is read; the first may still be settling
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			vpp_s1  <= 1'b0;
			vpp_s2  <= 1'b0;
			mode_s1 <= 1'b0;
			mode_s2 <= 1'b0;
		end else if (clk_en) begin
			vpp_s1  <= vpp_present_pin;
			vpp_s2  <= vpp_s1;
			mode_s1 <= special_mode;
			mode_s2 <= mode_s1;
		end
	end

	// mode gate and array enable
	// Sampled every cycle: leaving special mode stops a burn once mode_s2 falls, two enabled cycles later
	assign prom_program_allow = mode_s2 && nonvolatile_options[PPS_ARRAY_EN_BIT];

	always_comb begin
		next_latch      = prom_latch_enable;
		next_volt       = prom_program_voltage_on;
		next_opts       = nonvolatile_options;
		next_laddr      = latched_addr;
		next_ldata      = latched_data;
		next_lvalid     = latched_valid;
		next_rd_pending = bus_rd;
		next_rd_array   = bus_rd && pps_in_array(bus_addr);
		next_rd_reg     = 8'h00;
		if (bus_wr && bus_addr == PPS_PROM_PROGRAM_CONTROL_ADDR) begin
			next_latch = bus_wdata[PPS_LATCH_BIT];
			// voltage bit needs latch already set
			if (prom_latch_enable) begin
				next_volt = bus_wdata[PPS_VOLT_BIT];
			end
			// Dropping the latch also drops voltage so a stale byte never burns
			if (!bus_wdata[PPS_LATCH_BIT]) begin
				next_volt   = 1'b0;
				next_lvalid = 1'b0;
			end
		end
		if (bus_wr && bus_addr == PPS_OPTS_ADDR) begin
			next_opts = (nonvolatile_options & ~PPS_OPTS_WMASK) | (bus_wdata & PPS_OPTS_WMASK);
		end
		// latch address and data on array write
		if (bus_wr && pps_in_array(bus_addr) && prom_latch_enable && prom_program_allow) begin
			next_laddr  = pps_offset(bus_addr);
			next_ldata  = bus_wdata;
			next_lvalid = 1'b1;
		end
		// Register read value captured a cycle ahead, shown while rd_pending
		if (bus_addr == PPS_PROM_PROGRAM_CONTROL_ADDR) begin
			next_rd_reg = 8'h00;
			next_rd_reg[PPS_LATCH_BIT] = prom_latch_enable;
			next_rd_reg[PPS_VOLT_BIT]  = prom_program_voltage_on;
		end else if (bus_addr == PPS_OPTS_ADDR) begin
			next_rd_reg = nonvolatile_options;
		end
	end

	// power follows the voltage bit, gated by mode and array enable
	// no burn without high voltage present
	assign burn = prom_program_voltage_on && latched_valid && vpp_s2 && prom_program_allow;

	// State mirrors burn so array_busy has a flop source
	always_comb begin
		next_state = state;
		unique case (state)
			PPS_IDLE: if (burn) next_state = PPS_BURN;
			PPS_BURN: if (!burn) next_state = PPS_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prom_latch_enable       <= 1'b0;
			prom_program_voltage_on <= 1'b0;
			nonvolatile_options     <= PPS_OPTS_RESET;
			latched_addr            <= '0;
			latched_data            <= PPS_ERASED;
			latched_valid           <= 1'b0;
			rd_pending              <= 1'b0;
			rd_array                <= 1'b0;
			rd_reg                  <= 8'h00;
			state                   <= PPS_IDLE;
		end else if (clk_en) begin
			prom_latch_enable       <= next_latch;
			prom_program_voltage_on <= next_volt;
			nonvolatile_options     <= next_opts;
			latched_addr            <= next_laddr;
			latched_data            <= next_ldata;
			latched_valid           <= next_lvalid;
			rd_pending              <= next_rd_pending;
			rd_array                <= next_rd_array;
			rd_reg                  <= next_rd_reg;
			state                   <= next_state;
		end
	end

	// Latch mode keeps the array port for programming only
	assign arr_rd_en = bus_rd && pps_in_array(bus_addr) && !prom_latch_enable;

	// reads served only with latch off
	pps_array pps_array_inst (
		.clock     (clock),
		.clk_en    (clk_en),
		.prog_en   (burn),
		.prog_addr (latched_addr),
		.prog_data (latched_data),
		.rd_en     (arr_rd_en),
		.rd_addr   (pps_offset(bus_addr)),
		.rd_data   (arr_rdata)
	);

	// Read data is a mux of registers, not one flop: a flop here would cost
	// a cycle against the one-cycle read answer
	logic [7:0] next_bus_rdata;
	always_comb begin
		next_bus_rdata = 8'h00;
		if (rd_pending) begin
			// latch mode hides the array: reads give erased value
			if (rd_array) next_bus_rdata = prom_latch_enable ? PPS_ERASED : arr_rdata;
			else next_bus_rdata = rd_reg;
		end
	end
	assign bus_rdata = next_bus_rdata;

	// Power is also gated by mode and option bit, so leaving special mode cuts it
	// power output follows voltage bit
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			prog_power_on <= 1'b0;
			array_busy    <= 1'b0;
		end else if (clk_en) begin
			prog_power_on <= next_volt && prom_program_allow;
			array_busy    <= (next_state == PPS_BURN);
		end
	end

	// voltage bit cannot rise without latch
	a_volt_needs_latch: assert property (@(posedge clock) disable iff (sys_rst)
		$rose(prom_program_voltage_on) |-> $past(prom_latch_enable))
		else $error("voltage set without latch");
	a_burn_needs_vpp: assert property (@(posedge clock) disable iff (sys_rst)
		(state == PPS_BURN) && $past(clk_en) |-> $past(vpp_s2))
		else $error("burn without vpp");
	a_burn_mode_gate: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && !mode_s2 |=> !array_busy)
		else $error("burn in normal mode");
	a_no_burn_unlatched: assert property (@(posedge clock) disable iff (sys_rst)
		!prom_latch_enable |-> !burn)
		else $error("burn with latch off");
	a_power_tracks: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && !prom_program_voltage_on && !next_volt |=> !prog_power_on)
		else $error("power without bit");

	// Programming steps as seen on the register bus
	sequence s_latch_armed;
		prom_latch_enable && prom_program_allow;
	endsequence
	sequence s_volt_request;
		clk_en && bus_wr && (bus_addr == PPS_PROM_PROGRAM_CONTROL_ADDR)
			&& bus_wdata[PPS_LATCH_BIT] && bus_wdata[PPS_VOLT_BIT];
	endsequence
	sequence s_volt_release;
		clk_en && bus_wr && (bus_addr == PPS_PROM_PROGRAM_CONTROL_ADDR) && !bus_wdata[PPS_VOLT_BIT];
	endsequence
	sequence s_power_applied;
		prom_program_voltage_on && prog_power_on;
	endsequence
	sequence s_array_store;
		clk_en && bus_wr && pps_in_array(bus_addr);
	endsequence
	sequence s_array_fetch;
		clk_en && bus_rd && !bus_wr && pps_in_array(bus_addr);
	endsequence

	// voltage write with latch armed applies power
	a_volt_write_lands: assert property (@(posedge clock) disable iff (sys_rst)
		s_latch_armed ##0 s_volt_request |=> s_power_applied)
		else $error("voltage request not applied");
	a_volt_release: assert property (@(posedge clock) disable iff (sys_rst)
		s_volt_release |=> !prom_program_voltage_on && !prog_power_on)
		else $error("power left on after release");
	// voltage write refused while latch clear
	a_volt_refused: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && bus_wr && (bus_addr == PPS_PROM_PROGRAM_CONTROL_ADDR) && !prom_latch_enable |=> !prom_program_voltage_on)
		else $error("voltage accepted without latch");

	// latch mode captures address and data
	a_latch_captures: assert property (@(posedge clock) disable iff (sys_rst)
		s_latch_armed ##0 s_array_store |=> latched_valid && (latched_data == $past(bus_wdata))
			&& (latched_addr == $past(pps_offset(bus_addr))))
		else $error("array write not latched");
	// array reads in latch mode give erased value
	a_fetch_hidden: assert property (@(posedge clock) disable iff (sys_rst)
		prom_latch_enable ##0 s_array_fetch |=> (bus_rdata == PPS_ERASED))
		else $error("array visible in latch mode");

	// nothing latched while latch is off
	a_unlatched_idle: assert property (@(posedge clock) disable iff (sys_rst)
		!prom_latch_enable |-> !latched_valid)
		else $error("latched byte with latch off");
	// option bit gates power and burn
	a_array_enable_gate: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && !nonvolatile_options[PPS_ARRAY_EN_BIT] |=> !prog_power_on && !array_busy)
		else $error("programming without array enable");
	a_power_needs_latch: assert property (@(posedge clock) disable iff (sys_rst)
		prog_power_on |-> prom_latch_enable)
		else $error("power on with latch off");

	// Watches the release itself, so it has no disable
	a_reset_clears: assert property (@(posedge clock)
		$fell(sys_rst) |-> !prom_latch_enable && !prom_program_voltage_on
			&& !prog_power_on && !array_busy)
		else $error("control state not cleared by reset");
endmodule : pps_sequencer

// [tb.sv]
module tb
	import pps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  exp;
	} pps_row_s;

	logic        clock;
	logic        sys_rst;
	logic        clk_en;
	logic        special_mode;
	logic        vpp_present_pin;
	logic [15:0] bus_addr;
	logic [7:0]  bus_wdata;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  bus_rdata;
	logic        prog_power_on;
	logic        array_busy;
	logic [7:0]  d;
	int          fails    = 0;
	int          compares = 0;
	// Registers after reset, array edges and unmapped space
	pps_row_s    rows [0:5] = '{'{16'h103b, 8'h00}, '{16'h103f, 8'h08}, '{16'hd000, 8'hff},
		'{16'hffff, 8'hff}, '{16'hcfff, 8'h00}, '{16'h1000, 8'h00}};

	pps_sequencer pps_sequencer_inst (
		.clock           (clock),
		.sys_rst         (sys_rst),
		.clk_en          (clk_en),
		.special_mode    (special_mode),
		.vpp_present_pin (vpp_present_pin),
		.bus_addr        (bus_addr),
		.bus_wdata       (bus_wdata),
		.bus_wr          (bus_wr),
		.bus_rd          (bus_rd),
		.bus_rdata       (bus_rdata),
		.prog_power_on   (prog_power_on),
		.array_busy      (array_busy)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge clock);
		bus_addr  <= a;
		bus_wdata <= v;
		bus_wr    <= 1'b1;
		@(posedge clock);
		bus_wr    <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge clock);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge clock);
		bus_rd   <= 1'b0;
		#1;
		v = bus_rdata;
	endtask : rd

	// One byte through latch, voltage on, voltage off and back to read mode
	task automatic burn(input logic [15:0] a, input logic [7:0] v, input logic ok);
		logic [7:0] r;
		repeat (4) @(posedge clock);
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h20);
		wr(a, v);
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h21);
		repeat (3) @(posedge clock);
		#1;
		check({7'h00, array_busy}, {7'h00, ok});
		if (ok) begin
			check({7'h00, prog_power_on}, 8'h01);
		end
		rd(a, r);
		check(r, PPS_ERASED);
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h20);
		repeat (2) @(posedge clock);
		#1;
		check({6'h00, prog_power_on, array_busy}, 8'h00);
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h00);
		rd(a, r);
		check(r, ok ? v : PPS_ERASED);
		$display("test burn %h done", a);
	endtask : burn

	initial begin
		#200us;
		fails++;
		final_report();
	end

	initial begin
		sys_rst         = 1'b1;
		clk_en          = 1'b1;
		special_mode    = 1'b1;
		// supply pin held high while programming
		vpp_present_pin = 1'b1;
		bus_addr        = 16'h0000;
		bus_wdata       = 8'h00;
		bus_wr          = 1'b0;
		bus_rd          = 1'b0;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
		foreach (rows[i]) begin
			rd(rows[i].addr, d);
			check(d, rows[i].exp);
		end
		$display("test register table done");
		// voltage bit refused while latch was still clear
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h21);
		rd(PPS_PROM_PROGRAM_CONTROL_ADDR, d);
		check(d, 8'h20);
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h00);
		wr(PPS_OPTS_ADDR, 8'h02);
		rd(PPS_OPTS_ADDR, d);
		check(d, 8'h0a);
		burn(16'hd000, 8'h55, 1'b1);
		burn(16'hffff, 8'h3c, 1'b1);
		special_mode <= 1'b0;
		burn(16'hd001, 8'h0f, 1'b0);
		special_mode    <= 1'b1;
		vpp_present_pin <= 1'b0;
		burn(16'hd002, 8'h0f, 1'b0);
		vpp_present_pin <= 1'b1;
		wr(PPS_OPTS_ADDR, 8'h00);
		burn(16'hd003, 8'h0f, 1'b0);
		wr(PPS_OPTS_ADDR, 8'h02);
		// plain array write outside latch mode
		wr(16'hd004, 8'h00);
		rd(16'hd004, d);
		check(d, PPS_ERASED);
		// reset in mid-run drops latch and voltage
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h20);
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h21);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		#1;
		check({7'h00, prog_power_on}, 8'h00);
		rd(PPS_PROM_PROGRAM_CONTROL_ADDR, d);
		check(d, PPS_PROM_PROGRAM_CONTROL_RESET);
		// Frozen clock enable drops the write
		clk_en <= 1'b0;
		wr(PPS_PROM_PROGRAM_CONTROL_ADDR, 8'h20);
		clk_en <= 1'b1;
		rd(PPS_PROM_PROGRAM_CONTROL_ADDR, d);
		check(d, PPS_PROM_PROGRAM_CONTROL_RESET);
		$display("test refusals and reset done");
		final_report();
	end
endmodule : tb
